// file: logic/exec_cfg.svh
// Constants for the shift, branch, call and compare execution block
`ifndef EXEC_CFG_SVH
`define EXEC_CFG_SVH
`define EXEC_PC_RESET   32'h0000_0000
`define EXEC_SEQ_STEP   32'h0000_0001
`define EXEC_DELAY_ADD  32'h0000_0003
`define EXEC_TRAP_LAST  5'h1b
`define EXEC_AUX_COUNT  8
`define EXEC_FLAG_N     3
`define EXEC_FLAG_Z     2
`define EXEC_FLAG_V     1
`define EXEC_FLAG_C     0
`define EXEC_FLAGS_W    4
`define EXEC_STACK_DEPTH 8
`endif

// file: logic/exec_pkg.sv
// Types shared by the execution block
package exec_pkg;
    typedef enum logic [3:0] {
        op_none,
        arith_shift_three_op,
        cond_jump_standard,
        cond_jump_delayed,
        uncond_jump_standard,
        uncond_jump_delayed,
        subroutine_invoke,
        subroutine_invoke_if,
        float_compare_two_op,
        float_compare_three_op,
        int_compare_two_op,
        int_compare_three_op,
        trap_request
    } op_e;
endpackage

// file: logic/stack_mem.sv
// Return-address stack storage with registered top word
`timescale 1ns/1ps
`default_nettype none
module stack_mem #(
    parameter int W     = 32,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    // Push port
    input  wire logic         push_i,
    input  wire logic [W-1:0] data_i,
    // Top of stack
    output logic      [W-1:0] top_o
);
    localparam int PW = $clog2(DEPTH);

    logic [W-1:0]  mem_q [DEPTH];
    logic [PW-1:0] ptr_q;

    // Pointer wraps; overflow silently overwrites the oldest entry
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ptr_q <= '0;
        end else if (push_i) begin
            ptr_q <= ptr_q + PW'(1);
        end
    end

    // Cleared so the idle top read never shows unknowns
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else if (push_i) begin
            mem_q[ptr_q] <= data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            top_o <= '0;
        end else if (push_i) begin
            top_o <= data_i;
        end else begin
            top_o <= mem_q[ptr_q - PW'(1)];
        end
    end
endmodule
`default_nettype wire

// file: logic/shift_branch_call_compare_exec.sv
// Execution of shift, branch, call, compare and trap-select instructions
`timescale 1ns/1ps
`default_nettype none
`include "exec_cfg.svh"
module shift_branch_call_compare_exec #(
    parameter int W   = 32,
    parameter int CW  = 7
) (
    // Clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       rst_n_i,
    // Decoded instruction from the front end
    input  wire logic                       op_valid_i,
    input  wire exec_pkg::op_e              op_i,
    input  wire logic                       cond_true_i,
    input  wire logic                       target_is_reg_i,
    input  wire logic [W-1:0]               target_i,
    input  wire logic [W-1:0]               first_operand_i,
    input  wire logic [W-1:0]               second_operand_i,
    input  wire logic [CW-1:0]              count_i,
    input  wire logic [4:0]                 trap_sel_i,
    // Auxiliary pointer register access
    input  wire logic                       aux_wr_i,
    input  wire logic [2:0]                 aux_wr_sel_i,
    input  wire logic [W-1:0]               aux_wr_data_i,
    input  wire logic [2:0]                 aux_rd_sel_i,
    output logic      [W-1:0]               aux_rd_data_o,
    // Results
    output logic      [W-1:0]               pc_o,
    output logic      [W-1:0]               result_o,
    output logic                            result_wr_o,
    output logic      [`EXEC_FLAGS_W-1:0]   flags_o,
    output logic                            flags_wr_o,
    output logic      [W-1:0]               stack_top_o,
    output logic                            stack_push_o,
    output logic      [4:0]                 trap_vec_o,
    output logic                            trap_req_o,
    output logic                            trap_err_o
);
    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [`EXEC_FLAGS_W-1:0] int_flags(input logic [W-1:0] a,
                                                           input logic [W-1:0] b);
        logic [W:0] d;
        logic [`EXEC_FLAGS_W-1:0] f;
        d = {1'b0, a} - {1'b0, b};
        f = '0;
        f[`EXEC_FLAG_N] = d[W-1];
        f[`EXEC_FLAG_Z] = (d[W-1:0] == '0);
        f[`EXEC_FLAG_V] = (a[W-1] != b[W-1]) && (d[W-1] != a[W-1]);
        f[`EXEC_FLAG_C] = d[W];
        return f;
    endfunction

    // Sign-magnitude order; no rounding, so V and C stay clear
    function automatic logic [`EXEC_FLAGS_W-1:0] flt_flags(input logic [W-1:0] a,
                                                           input logic [W-1:0] b);
        logic a_zero;
        logic b_zero;
        logic lt;
        logic [`EXEC_FLAGS_W-1:0] f;
        a_zero = (a[W-2:0] == '0);
        b_zero = (b[W-2:0] == '0);
        if (a_zero && b_zero) begin
            lt = 1'b0;
        end else if (a[W-1] != b[W-1]) begin
            lt = a[W-1];
        end else if (a[W-1]) begin
            lt = a[W-2:0] > b[W-2:0];
        end else begin
            lt = a[W-2:0] < b[W-2:0];
        end
        f = '0;
        f[`EXEC_FLAG_N] = lt;
        f[`EXEC_FLAG_Z] = (a == b) || (a_zero && b_zero);
        return f;
    endfunction

    // ************************************************************
    // Decode
    // ************************************************************
    logic [W-1:0] pc_q;
    logic [W-1:0] seq_pc;
    logic         is_call;
    logic         is_call_if;
    logic         push_w;
    logic         cnt_neg;
    logic [CW-1:0] cnt_mag;

    assign seq_pc     = pc_q + `EXEC_SEQ_STEP;
    assign is_call    = op_valid_i && (op_i == exec_pkg::subroutine_invoke);
    assign is_call_if = op_valid_i && (op_i == exec_pkg::subroutine_invoke_if);
    assign push_w     = is_call || (is_call_if && cond_true_i);
    assign cnt_neg    = count_i[CW-1];
    assign cnt_mag    = cnt_neg ? CW'(-count_i) : count_i;
    assign stack_push_o = push_w;

    // ************************************************************
    // Program counter
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pc_q <= `EXEC_PC_RESET;
        end else if (op_valid_i) begin
            case (op_i)
                exec_pkg::cond_jump_standard,
                exec_pkg::subroutine_invoke_if: begin
                    if (!cond_true_i) begin
                        pc_q <= seq_pc;
                    end else if (target_is_reg_i) begin
                        pc_q <= target_i;
                    end else begin
                        pc_q <= pc_q + target_i;
                    end
                end
                exec_pkg::cond_jump_delayed: begin
                    if (!cond_true_i) begin
                        pc_q <= seq_pc;
                    end else if (target_is_reg_i) begin
                        pc_q <= target_i;
                    end else begin
                        pc_q <= pc_q + target_i + `EXEC_DELAY_ADD;
                    end
                end
                exec_pkg::uncond_jump_standard,
                exec_pkg::uncond_jump_delayed,
                exec_pkg::subroutine_invoke: begin
                    pc_q <= target_i;
                end
                default: begin
                    pc_q <= seq_pc;
                end
            endcase
        end
    end
    assign pc_o = pc_q;

    stack_mem #(
        .W     (W),
        .DEPTH (`EXEC_STACK_DEPTH)
    ) u_stack (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .push_i  (push_w),
        .data_i  (seq_pc),
        .top_o   (stack_top_o)
    );

    // ************************************************************
    // Shift result
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            result_o    <= '0;
            result_wr_o <= 1'b0;
        end else begin
            result_wr_o <= op_valid_i && (op_i == exec_pkg::arith_shift_three_op);
            if (op_valid_i && (op_i == exec_pkg::arith_shift_three_op)) begin
                if (!cnt_neg) begin
                    result_o <= first_operand_i << cnt_mag;
                end else begin
                    result_o <= W'($signed(first_operand_i) >>> cnt_mag);
                end
            end
        end
    end

    // ************************************************************
    // Compare flags
    // ************************************************************
    // Compares never touch result_o; only flags move
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            flags_o    <= '0;
            flags_wr_o <= 1'b0;
        end else begin
            flags_wr_o <= 1'b0;
            if (op_valid_i) begin
                case (op_i)
                    exec_pkg::float_compare_two_op,
                    exec_pkg::float_compare_three_op: begin
                        flags_o    <= flt_flags(first_operand_i, second_operand_i);
                        flags_wr_o <= 1'b1;
                    end
                    exec_pkg::int_compare_two_op,
                    exec_pkg::int_compare_three_op: begin
                        flags_o    <= int_flags(first_operand_i, second_operand_i);
                        flags_wr_o <= 1'b1;
                    end
                    default: begin
                        flags_wr_o <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ************************************************************
    // Auxiliary pointers and trap select
    // ************************************************************
    logic [W-1:0] aux_q [`EXEC_AUX_COUNT];

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < `EXEC_AUX_COUNT; i++) begin
                aux_q[i] <= '0;
            end
        end else if (aux_wr_i) begin
            aux_q[aux_wr_sel_i] <= aux_wr_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            aux_rd_data_o <= '0;
        end else begin
            aux_rd_data_o <= aux_q[aux_rd_sel_i];
        end
    end

    // Out-of-range selectors are refused, never wrapped
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            trap_vec_o <= '0;
            trap_req_o <= 1'b0;
            trap_err_o <= 1'b0;
        end else begin
            trap_req_o <= 1'b0;
            trap_err_o <= 1'b0;
            if (op_valid_i && (op_i == exec_pkg::trap_request)) begin
                if (trap_sel_i <= `EXEC_TRAP_LAST) begin
                    trap_vec_o <= trap_sel_i;
                    trap_req_o <= 1'b1;
                end else begin
                    trap_err_o <= 1'b1;
                end
            end
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    chk_shift_dir: assert property (
        op_valid_i && op_i == exec_pkg::arith_shift_three_op && !count_i[CW-1]
        |=> result_wr_o && result_o == ($past(first_operand_i) << $past(count_i)))
        else $error("left shift result wrong");
    chk_disp_delay: assert property (
        op_valid_i && op_i == exec_pkg::cond_jump_delayed && cond_true_i && !target_is_reg_i
        |=> pc_o == $past(pc_o) + $past(target_i) + `EXEC_DELAY_ADD)
        else $error("delayed displacement target wrong");
    chk_false_seq: assert property (
        op_valid_i && !cond_true_i && (op_i == exec_pkg::cond_jump_standard ||
        op_i == exec_pkg::subroutine_invoke_if)
        |-> !stack_push_o ##1 pc_o == $past(pc_o) + `EXEC_SEQ_STEP)
        else $error("false condition did not step");
    chk_call_push: assert property (
        op_valid_i && op_i == exec_pkg::subroutine_invoke
        |-> stack_push_o ##1 stack_top_o == $past(pc_o) + `EXEC_SEQ_STEP)
        else $error("call return address wrong");
    chk_fcmp_flags: assert property (
        op_valid_i && op_i == exec_pkg::float_compare_two_op && first_operand_i == second_operand_i
        |=> flags_wr_o && flags_o[`EXEC_FLAG_Z] && !result_wr_o)
        else $error("float compare flags wrong");
    chk_icmp_order: assert property (
        op_valid_i && op_i == exec_pkg::int_compare_two_op
        |=> flags_o[`EXEC_FLAG_C] == ($past(first_operand_i) < $past(second_operand_i))
            && !result_wr_o)
        else $error("int compare borrow wrong");
    chk_cmp3_zero: assert property (
        op_valid_i && op_i == exec_pkg::int_compare_three_op
        |=> flags_o[`EXEC_FLAG_Z] == ($past(first_operand_i) == $past(second_operand_i)))
        else $error("three-operand compare zero wrong");
    chk_aux_read: assert property (
        aux_wr_i ##1 (aux_rd_sel_i == $past(aux_wr_sel_i)) && !aux_wr_i
        |=> aux_rd_data_o == $past(aux_wr_data_i, 2))
        else $error("aux register readback wrong");
    chk_trap_range: assert property (
        op_valid_i && op_i == exec_pkg::trap_request
        |=> trap_req_o == ($past(trap_sel_i) <= `EXEC_TRAP_LAST) && trap_err_o == !trap_req_o)
        else $error("trap selector range wrong");
    chk_reg_target: assert property (
        op_valid_i && (op_i == exec_pkg::uncond_jump_delayed ||
        (op_i == exec_pkg::cond_jump_standard && cond_true_i && target_is_reg_i))
        |=> pc_o == $past(target_i))
        else $error("register target not loaded");

    cov_call_if: cover property (is_call_if && cond_true_i);
    cov_neg_shift: cover property (
        op_valid_i && op_i == exec_pkg::arith_shift_three_op && cnt_neg);
    cov_bad_trap: cover property (trap_err_o);
endmodule
`default_nettype wire

// file: bench/front_end_model.sv
// Front-end model that issues decoded instructions to the execution block
`timescale 1ns/1ps
`default_nettype none
module front_end_model #(
    parameter int W  = 32,
    parameter int CW = 7
) (
    // Clock
    input  wire logic          clk_i,
    // Decoded instruction
    output logic               op_valid_o,
    output exec_pkg::op_e      op_o,
    output logic               cond_true_o,
    output logic               target_is_reg_o,
    output logic      [W-1:0]  target_o,
    output logic      [W-1:0]  first_operand_o,
    output logic      [W-1:0]  second_operand_o,
    output logic      [CW-1:0] count_o,
    output logic      [4:0]    trap_sel_o
);
    initial begin
        op_valid_o = 1'b0;
        op_o = exec_pkg::op_none;
        cond_true_o = 1'b0;
        target_is_reg_o = 1'b0;
        target_o = 32'h0000_0000;
        first_operand_o = 32'h0000_0000;
        second_operand_o = 32'h0000_0000;
        count_o = 7'h00;
        trap_sel_o = 5'h00;
    end

    // Called just after a rising edge; returns at the edge that takes it
    task automatic issue(input exec_pkg::op_e op, input logic c, input logic r,
                         input logic [W-1:0] t, input logic [W-1:0] a,
                         input logic [W-1:0] b, input logic [CW-1:0] n,
                         input logic [4:0] s);
        op_valid_o <= 1'b1;
        op_o <= op;
        cond_true_o <= c;
        target_is_reg_o <= r;
        target_o <= t;
        first_operand_o <= a;
        second_operand_o <= b;
        count_o <= n;
        trap_sel_o <= s;
        @(posedge clk_i);
    endtask

    // Stale target and first-operand fields are scrambled so nothing leans on old values
    task automatic idle(input int cycles);
        op_valid_o <= 1'b0;
        target_o <= ~target_o;
        first_operand_o <= ~first_operand_o;
        repeat (cycles) @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

// file: bench/shift_branch_call_compare_exec_tb.sv
// Self-checking bench for the execution block with a reference model
`timescale 1ns/1ps
`default_nettype none
module shift_branch_call_compare_exec_tb;
    localparam int W  = 32;
    localparam int CW = 7;
    logic clk_i, rst_n_i, op_valid_i, cond_true_i, target_is_reg_i, aux_wr_i, aux_chk;
    exec_pkg::op_e op_i;
    logic [W-1:0] target_i, first_operand_i, second_operand_i, aux_wr_data_i;
    logic [CW-1:0] count_i;
    logic [4:0] trap_sel_i, trap_vec_o, vec_m;
    logic [2:0] aux_wr_sel_i, aux_rd_sel_i;
    logic [W-1:0] aux_rd_data_o, pc_o, result_o, stack_top_o, pc_m, res_m, top_m, d, aux_e;
    logic [3:0] flags_o, flg_m;
    logic result_wr_o, flags_wr_o, stack_push_o, trap_req_o, trap_err_o;
    logic rwr_m, fwr_m, treq_m, terr_m, push_m, do_aux;
    logic [W-1:0] aux_m [8];
    longint ka, kb;
    int err_count, num_checks, n;

    always #20 clk_i = ~clk_i;

    front_end_model #(.W(W), .CW(CW)) i_fe (.clk_i(clk_i), .op_valid_o(op_valid_i),
        .op_o(op_i), .cond_true_o(cond_true_i), .target_is_reg_o(target_is_reg_i),
        .target_o(target_i), .first_operand_o(first_operand_i),
        .second_operand_o(second_operand_i), .count_o(count_i), .trap_sel_o(trap_sel_i));

    shift_branch_call_compare_exec #(.W(W), .CW(CW)) i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .op_valid_i(op_valid_i), .op_i(op_i), .cond_true_i(cond_true_i),
        .target_is_reg_i(target_is_reg_i), .target_i(target_i),
        .first_operand_i(first_operand_i), .second_operand_i(second_operand_i),
        .count_i(count_i), .trap_sel_i(trap_sel_i), .aux_wr_i(aux_wr_i),
        .aux_wr_sel_i(aux_wr_sel_i), .aux_wr_data_i(aux_wr_data_i),
        .aux_rd_sel_i(aux_rd_sel_i), .aux_rd_data_o(aux_rd_data_o), .pc_o(pc_o),
        .result_o(result_o), .result_wr_o(result_wr_o), .flags_o(flags_o),
        .flags_wr_o(flags_wr_o), .stack_top_o(stack_top_o), .stack_push_o(stack_push_o),
        .trap_vec_o(trap_vec_o), .trap_req_o(trap_req_o), .trap_err_o(trap_err_o));

    task automatic chk(input logic [W-1:0] got, input logic [W-1:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // ****************************************************
    // Reference model, updated at each edge, compared 1 ns later
    // ****************************************************
    always @(posedge clk_i) begin
        push_m = op_valid_i && (op_i == exec_pkg::subroutine_invoke ||
                 (op_i == exec_pkg::subroutine_invoke_if && cond_true_i));
        chk(32'(stack_push_o), 32'(push_m));
        do_aux = aux_chk && rst_n_i;
        aux_e = aux_m[aux_rd_sel_i];
        {rwr_m, fwr_m, treq_m, terr_m} = 4'h0;
        if (!rst_n_i) begin
            {pc_m, res_m, top_m, flg_m, vec_m} = '0;
            for (int i = 0; i < 8; i++) aux_m[i] = 32'h0000_0000;
        end else begin
            if (aux_wr_i) aux_m[aux_wr_sel_i] = aux_wr_data_i;
            if (op_valid_i) begin
                d = first_operand_i - second_operand_i;
                ka = first_operand_i[31] ? -longint'(first_operand_i[30:0]) : first_operand_i[30:0];
                kb = second_operand_i[31] ? -longint'(second_operand_i[30:0])
                                          : second_operand_i[30:0];
                n = $signed(count_i);
                case (op_i)
                    exec_pkg::arith_shift_three_op: begin
                        // Kept apart: a shared conditional would turn >>> logical
                        if (n >= 0) res_m = first_operand_i << n;
                        else res_m = $signed(first_operand_i) >>> -n;
                        rwr_m = 1'b1;
                    end
                    exec_pkg::int_compare_two_op, exec_pkg::int_compare_three_op: begin
                        flg_m = {d[31], d == 32'h0, (first_operand_i[31] != second_operand_i[31])
                                 && (d[31] != first_operand_i[31]),
                                 first_operand_i < second_operand_i};
                        fwr_m = 1'b1;
                    end
                    exec_pkg::float_compare_two_op, exec_pkg::float_compare_three_op: begin
                        flg_m = {ka < kb, ka == kb, 2'b00};
                        fwr_m = 1'b1;
                    end
                    exec_pkg::trap_request: begin
                        treq_m = (trap_sel_i <= 5'd27);
                        terr_m = !treq_m;
                        if (treq_m) vec_m = trap_sel_i;
                    end
                    default: ;
                endcase
                if (push_m) top_m = pc_m + 32'h1;
                case (op_i)
                    exec_pkg::cond_jump_standard, exec_pkg::cond_jump_delayed,
                    exec_pkg::subroutine_invoke_if: begin
                        if (!cond_true_i) pc_m = pc_m + 32'h1;
                        else if (target_is_reg_i) pc_m = target_i;
                        else pc_m = pc_m + target_i +
                                    ((op_i == exec_pkg::cond_jump_delayed) ? 32'h3 : 32'h0);
                    end
                    exec_pkg::uncond_jump_standard, exec_pkg::uncond_jump_delayed,
                    exec_pkg::subroutine_invoke: pc_m = target_i;
                    default: pc_m = pc_m + 32'h1;
                endcase
            end
        end
        #1;
        chk(pc_o, pc_m);
        chk(stack_top_o, top_m);
        chk(result_o, res_m);
        chk({result_wr_o, flags_wr_o, flags_o}, {rwr_m, fwr_m, flg_m});
        chk({trap_vec_o, trap_req_o, trap_err_o}, {vec_m, treq_m, terr_m});
        if (do_aux) chk(aux_rd_data_o, aux_e);
    end

    task automatic aux_pass(input logic wr);
        for (int i = 0; i < 8; i++) begin
            aux_wr_i <= wr;
            aux_wr_sel_i <= 3'(i);
            aux_wr_data_i <= $urandom();
            @(posedge clk_i);
        end
        aux_wr_i <= 1'b0;
        aux_chk <= 1'b1;
        for (int i = 7; i >= 0; i--) begin
            aux_rd_sel_i <= 3'(i);
            @(posedge clk_i);
        end
        aux_chk <= 1'b0;
    endtask

    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        {clk_i, rst_n_i, aux_wr_i, aux_chk, aux_wr_sel_i, aux_rd_sel_i} = '0;
        aux_wr_data_i = 32'h0000_0000;
        err_count = 0;
        num_checks = 0;
        void'($urandom(19939));
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        // Every opcode with each condition and target kind
        for (int op = 0; op < 13; op++)
            for (int k = 0; k < 4; k++)
                i_fe.issue(exec_pkg::op_e'(op), k[0], k[1], $urandom(), $urandom(),
                           $urandom(), 7'($urandom()), 5'($urandom()));
        $display("test table done");
        // Boundary counts, vectors and equal operands, back to back
        i_fe.issue(exec_pkg::arith_shift_three_op, 0, 0, 0, 32'h8000_0001, 0, 7'h00, 0);
        i_fe.issue(exec_pkg::arith_shift_three_op, 0, 0, 0, 32'h8000_0001, 0, 7'h40, 0);
        i_fe.issue(exec_pkg::arith_shift_three_op, 0, 0, 0, 32'h8000_0001, 0, 7'h7f, 0);
        i_fe.issue(exec_pkg::arith_shift_three_op, 0, 0, 0, 32'h4000_0001, 0, 7'h3f, 0);
        i_fe.issue(exec_pkg::trap_request, 0, 0, 0, 0, 0, 0, 5'h1b);
        i_fe.issue(exec_pkg::trap_request, 0, 0, 0, 0, 0, 0, 5'h1c);
        i_fe.issue(exec_pkg::int_compare_three_op, 0, 0, 0, 32'h7fff_ffff, 32'h7fff_ffff,
                   0, 0);
        i_fe.issue(exec_pkg::int_compare_two_op, 0, 0, 0, 32'h8000_0000, 32'h1, 0, 0);
        i_fe.issue(exec_pkg::float_compare_two_op, 0, 0, 0, 32'h8000_0000, 32'h0, 0, 0);
        i_fe.issue(exec_pkg::float_compare_two_op, 0, 0, 0, 32'h3f80_0000, 32'h3f80_0000,
                   0, 0);
        i_fe.issue(exec_pkg::cond_jump_delayed, 1, 0, 32'hffff_fffd, 0, 0, 0, 0);
        $display("test boundary done");
        // Random stream with occasional stalls from the front end
        repeat (300) begin
            i_fe.issue(exec_pkg::op_e'($urandom_range(12, 0)), 1'($urandom()), 1'($urandom()),
                       $urandom(), $urandom(), $urandom(), 7'($urandom()), 5'($urandom()));
            if ($urandom_range(3, 0) == 0) i_fe.idle($urandom_range(3, 1));
        end
        i_fe.idle(1);
        $display("test random done");
        aux_pass(1'b1);
        $display("test aux done");
        // Reset mid-run clears state, then a call pushes again
        rst_n_i <= 1'b0;
        @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        aux_pass(1'b0);
        i_fe.issue(exec_pkg::subroutine_invoke_if, 1, 0, 32'h20, 0, 0, 0, 0);
        i_fe.idle(2);
        $display("test rereset done");
        finish_test();
    end
endmodule
`default_nettype wire
